// [tmcw_bank.sv]
/*
  Test-mode and continuous-wave Doppler configuration bank with the test
  pattern data path. Assumes the serial control port delivers decoded byte
  accesses on clk, and the chip address straps arrive asynchronously.
*/
`timescale 1ns/1ps
module tmcw_bank (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [12:0]  reg_addr,
  input  wire logic         reg_wr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_rd,
  output logic      [7:0]   reg_rdata,
  output logic              reg_rvalid,
  input  wire logic [4:0]   chip_addr_pin,
  input  wire logic         sample_strobe,
  input  wire logic [127:0] conv_data,
  output logic      [127:0] out_data,
  output logic      [7:0]   analog_tone_en,
  output logic              iq_swap,
  output logic              preamp_offset_cancel_en,
  output logic      [1:0]   offset_cancel_gm,
  output logic              tone_force_lo,
  output logic              tone_force_dc
);
  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Eight-step sine table indexed by phase.
  function automatic logic [15:0] tmcw_sine(input logic [2:0] ph);
    case (ph)
      3'h0:    tmcw_sine = 16'h0000;
      3'h1:    tmcw_sine = 16'h16a0;
      3'h2:    tmcw_sine = 16'h1fff;
      3'h3:    tmcw_sine = 16'h16a0;
      3'h4:    tmcw_sine = 16'h0000;
      3'h5:    tmcw_sine = 16'he960;
      3'h6:    tmcw_sine = 16'he001;
      default: tmcw_sine = 16'he960;
    endcase
  endfunction : tmcw_sine

  // Address match for a register write.
  function automatic logic tmcw_wr_hit(input logic [12:0] a,
                                       input logic [12:0] target);
    tmcw_wr_hit = (a == target);
  endfunction : tmcw_wr_hit

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0]   chan_en;        // Per-channel test enables.
  logic [2:0]   test_sel;       // Global test selection.
  logic [6:0]   dop_ctrl;       // Stored Doppler control bits.
  logic [7:0]   next_chan_en;   // Next enables.
  logic [2:0]   next_test_sel;  // Next selection.
  logic [6:0]   next_dop_ctrl;  // Next Doppler control.
  logic [7:0]   next_rdata;     // Next read data.
  logic         next_rvalid;    // Next read valid.

  // Computes register updates and read answers.
  always_comb
  begin
    next_chan_en  = chan_en;
    next_test_sel = test_sel;
    next_dop_ctrl = dop_ctrl;
    next_rdata    = reg_rdata;
    next_rvalid   = reg_rd;
    if (reg_wr)
    begin
      if (tmcw_wr_hit(reg_addr, tmcw_pkg::ADDR_CHANNEL_TEST_ENABLES))
        next_chan_en = reg_wdata;
      // Only the low field is kept; a single global copy exists.
      if (tmcw_wr_hit(reg_addr, tmcw_pkg::ADDR_TEST_SELECTION))
        next_test_sel = reg_wdata[tmcw_pkg::SEL_MSB:0];
      if (tmcw_wr_hit(reg_addr, tmcw_pkg::ADDR_DOPPLER_CTRL))
      begin
        next_dop_ctrl = reg_wdata[6:0];
        next_dop_ctrl[2] = 1'b0;  // Unused bit stays clear.
      end
    end
    if (reg_rd)
    begin
      case (reg_addr)
        tmcw_pkg::ADDR_CHANNEL_TEST_ENABLES: next_rdata = chan_en;
        tmcw_pkg::ADDR_TEST_SELECTION:       next_rdata = {5'h00, test_sel};
        tmcw_pkg::ADDR_DOPPLER_CTRL:         next_rdata = {1'b0, dop_ctrl};
        tmcw_pkg::ADDR_SPARE_A,
        tmcw_pkg::ADDR_SPARE_B,
        tmcw_pkg::ADDR_SPARE_C,
        tmcw_pkg::ADDR_SPARE_D:   next_rdata = tmcw_pkg::RST_SPARE_ABCD;
        tmcw_pkg::ADDR_SPARE_E:   next_rdata = tmcw_pkg::RST_SPARE_E;
        default:                  next_rdata = 8'h00;  // Unmapped.
      endcase
    end
  end

  // Registers the bank; reset gives the documented defaults.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      chan_en    <= tmcw_pkg::RST_CHANNEL_TEST_ENABLES;
      test_sel   <= tmcw_pkg::RST_TEST_SELECTION[2:0];
      dop_ctrl   <= tmcw_pkg::RST_DOPPLER_CTRL[6:0];
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      chan_en    <= next_chan_en;
      test_sel   <= next_test_sel;
      dop_ctrl   <= next_dop_ctrl;
      reg_rdata  <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  // ---------------------------------------------------------------
  // Chip address synchroniser
  // ---------------------------------------------------------------
  logic [4:0] addr_meta;  // First stage, read only by the second.
  logic [4:0] addr_sync;  // Stable chip address.

  // Two flip-flops bring the strap pins onto clk.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_meta <= 5'h00;
      addr_sync <= 5'h00;
    end
    else
    begin
      addr_meta <= chip_addr_pin;
      addr_sync <= addr_meta;
    end
  end

  // ---------------------------------------------------------------
  // Test pattern data path and control outputs
  // ---------------------------------------------------------------
  logic [6:0]   ramp;             // Channel-ID ramp counter.
  logic [2:0]   phase;            // Sine phase.
  logic [6:0]   next_ramp;
  logic [2:0]   next_phase;
  logic [127:0] next_out_data;
  logic [7:0]   next_tone_en;
  logic [3:0]   ctl_bits;         // Next control outputs, packed.

  // Selects per-channel data; undefined codes leave data untouched.
  always_comb
  begin
    next_ramp     = ramp;
    next_phase    = phase;
    next_out_data = out_data;
    for (int ch = 0; ch < tmcw_pkg::NUM_CH; ch++)
    begin
      // Tone injection follows the enables only under code 100.
      next_tone_en[ch] = chan_en[ch] &&
                         (test_sel == tmcw_pkg::SEL_TONE);
    end
    if (sample_strobe)
    begin
      next_phase = phase + 3'h1;
      if (test_sel == tmcw_pkg::SEL_CHAN_ID)
        next_ramp = ramp + 7'h01;
      for (int ch = 0; ch < tmcw_pkg::NUM_CH; ch++)
      begin
        if (chan_en[ch] && test_sel == tmcw_pkg::SEL_SINE)
          next_out_data[ch*16 +: 16] = tmcw_sine(phase);
        else if (chan_en[ch] && test_sel == tmcw_pkg::SEL_CHAN_ID)
          next_out_data[ch*16 +: 16] =
            {ramp, 1'b0, 3'(ch), addr_sync};
        else
        begin
          // Off, tone, reserved codes or disabled channel pass data.
          next_out_data[ch*16 +: 16] = conv_data[ch*16 +: 16];
        end
      end
    end
    ctl_bits    = 4'h0;
    ctl_bits[0] = dop_ctrl[tmcw_pkg::SWAP_BIT];
    ctl_bits[1] = ~dop_ctrl[tmcw_pkg::OFS_DIS_BIT];
    ctl_bits[2] = (dop_ctrl[tmcw_pkg::OVR_MSB:tmcw_pkg::OVR_LSB] ==
                   2'h1);
    ctl_bits[3] = dop_ctrl[tmcw_pkg::OVR_MSB];
  end

  // Registers the data path and control outputs.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ramp                    <= 7'h00;
      phase                   <= 3'h0;
      out_data                <= 128'h0;
      analog_tone_en          <= 8'h00;
      iq_swap                 <= 1'b0;
      preamp_offset_cancel_en <= 1'b1;
      offset_cancel_gm        <= 2'h0;
      tone_force_lo           <= 1'b0;
      tone_force_dc           <= 1'b0;
    end
    else
    begin
      ramp                    <= next_ramp;
      phase                   <= next_phase;
      out_data                <= next_out_data;
      analog_tone_en          <= next_tone_en;
      iq_swap                 <= ctl_bits[0];
      preamp_offset_cancel_en <= ctl_bits[1];
      offset_cancel_gm        <= dop_ctrl[tmcw_pkg::GM_MSB:tmcw_pkg::GM_LSB];
      tone_force_lo           <= ctl_bits[2];
      tone_force_dc           <= ctl_bits[3];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_reset_off;
    @(posedge clk) rst |=> (test_sel == 3'h0) && (chan_en == 8'h00);
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("Test state not cleared by reset.");
  property p_sine;
    @(posedge clk) disable iff (rst)
      (sample_strobe && chan_en[0] && test_sel == 3'h1)
      |=> out_data[15:0] == tmcw_sine($past(phase));
  endproperty
  a_sine: assert property (p_sine)
    else $error("Sine word wrong on channel zero.");
  property p_chan_id;
    @(posedge clk) disable iff (rst)
      (sample_strobe && chan_en[1] && test_sel == 3'h3)
      |=> out_data[31:16] == {$past(ramp), 1'b0, 3'h1, $past(addr_sync)};
  endproperty
  a_chan_id: assert property (p_chan_id)
    else $error("Channel ID word wrong on channel one.");
  property p_tone;
    @(posedge clk) disable iff (rst)
      ##1 analog_tone_en == ($past(test_sel) == 3'h4 ? $past(chan_en)
                                                     : 8'h00);
  endproperty
  a_tone: assert property (p_tone)
    else $error("Tone enable does not follow selection.");
  property p_sel_write;
    @(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == tmcw_pkg::ADDR_TEST_SELECTION)
      |=> test_sel == $past(reg_wdata[2:0]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("Selection write not taken.");
  property p_swap;
    @(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == tmcw_pkg::ADDR_DOPPLER_CTRL)
      |=> ##1 iq_swap == $past(reg_wdata[6], 2);
  endproperty
  a_swap: assert property (p_swap)
    else $error("Swap output wrong after write.");
  property p_ofs;
    @(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == tmcw_pkg::ADDR_DOPPLER_CTRL) |=> ##1
        preamp_offset_cancel_en == !$past(reg_wdata[5], 2);
  endproperty
  a_ofs: assert property (p_ofs)
    else $error("Offset cancellation polarity wrong.");
  property p_override;
    @(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == tmcw_pkg::ADDR_DOPPLER_CTRL && reg_wdata[1])
      |=> ##1 tone_force_dc && !tone_force_lo;
  endproperty
  a_override: assert property (p_override)
    else $error("Override to dc not applied.");
  property p_pass;
    @(posedge clk) disable iff (rst)
      (sample_strobe && !chan_en[2])
      |=> out_data[47:32] == $past(conv_data[47:32]);
  endproperty
  a_pass: assert property (p_pass)
    else $error("Disabled channel did not pass data.");
endmodule : tmcw_bank

// [tmcw_pkg.sv]
/*
  Constants shared by the test-mode and continuous-wave Doppler control bank.
  Assumes a byte-wide register port from the serial control port decoder.
*/
package tmcw_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [12:0] ADDR_CHANNEL_TEST_ENABLES = 13'h0_11a;
  localparam logic [12:0] ADDR_TEST_SELECTION       = 13'h0_11b;
  localparam logic [12:0] ADDR_SPARE_A              = 13'h0_11c;
  localparam logic [12:0] ADDR_SPARE_B              = 13'h0_11d;
  localparam logic [12:0] ADDR_SPARE_C              = 13'h0_11e;
  localparam logic [12:0] ADDR_SPARE_D              = 13'h0_11f;
  localparam logic [12:0] ADDR_DOPPLER_CTRL         = 13'h0_120;
  localparam logic [12:0] ADDR_SPARE_E              = 13'h0_180;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CHANNEL_TEST_ENABLES = 8'h00;
  localparam logic [7:0] RST_TEST_SELECTION       = 8'h00;
  localparam logic [7:0] RST_SPARE_ABCD           = 8'h00;
  localparam logic [7:0] RST_DOPPLER_CTRL         = 8'h00;
  localparam logic [7:0] RST_SPARE_E              = 8'h87;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SEL_MSB      = 2;  // Test selection field top bit.
  localparam int SWAP_BIT     = 6;  // Doppler I/Q swap control.
  localparam int OFS_DIS_BIT  = 5;  // Preamp offset cancellation off.
  localparam int GM_MSB       = 4;  // Cancellation transconductance.
  localparam int GM_LSB       = 3;
  localparam int OVR_MSB      = 1;  // Tone frequency override field.
  localparam int OVR_LSB      = 0;

  // ---------------------------------------------------------------
  // Test selection codes
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_OFF     = 3'h0;
  localparam logic [2:0] SEL_SINE    = 3'h1;
  localparam logic [2:0] SEL_CHAN_ID = 3'h3;
  localparam logic [2:0] SEL_TONE    = 3'h4;

  localparam int NUM_CH = 8;  // Channel count.
endpackage : tmcw_pkg

// [tb_tmcw_bank.sv]
/*
  Self-checking testbench for the test-mode and Doppler control bank.
  Assumes the bank's assertions live in the design files, and that the
  bench alone drives every input port except clk on the falling edge of clk.
*/
`timescale 1ns/1ps
module tb_tmcw_bank;
  // ---------------------------------------------------------------
  // Signals and bookkeeping
  // ---------------------------------------------------------------
  logic           clk;                      // 200 MHz clock.
  logic           rst;                      // Synchronous reset.
  logic [12:0]    reg_addr;                 // Register address.
  logic           reg_wr;                   // Write strobe.
  logic [7:0]     reg_wdata;                // Write data.
  logic           reg_rd;                   // Read strobe.
  logic [7:0]     reg_rdata;                // Read data.
  logic           reg_rvalid;               // Read data valid.
  logic [4:0]     chip_addr_pin;            // Strapped chip address.
  logic           sample_strobe;            // Converter sample pulse.
  logic [127:0]   conv_data;                // Converter words.
  logic [127:0]   out_data;                 // Channel output words.
  logic [7:0]     analog_tone_en;           // Tone injection enables.
  logic           iq_swap;                  // Doppler I/Q swap.
  logic           preamp_offset_cancel_en;  // Offset cancellation on.
  logic [1:0]     offset_cancel_gm;         // Cancellation strength.
  logic           tone_force_lo;            // Tone at oscillator rate.
  logic           tone_force_dc;            // Tone forced to dc.
  int             failures;                 // Mismatch count.
  int             checks;                   // Comparison count.
  int             seed;                     // Random seed.
  logic [7:0]     rq[$];                    // Expected read data.
  logic [127:0]   dq[$];                    // Expected channel data.
  logic           strb_seen;                // Strobe taken last edge.
  logic [2:0]     sel;                      // Selection in force.
  logic [7:0]     en;                       // Channel enables in force.
  logic [2:0]     phase;                    // Sine position.
  logic [6:0]     ramp;                     // Identification ramp.
  logic [7:0]     v;                        // Scratch register value.
  logic [15:0]    sine [8] = '{16'h0000, 16'h16a0, 16'h1fff, 16'h16a0,
                               16'h0000, 16'he960, 16'he001, 16'he960};

  tmcw_bank u_dut (
    .clk                     (clk),
    .rst                     (rst),
    .reg_addr                (reg_addr),
    .reg_wr                  (reg_wr),
    .reg_wdata               (reg_wdata),
    .reg_rd                  (reg_rd),
    .reg_rdata               (reg_rdata),
    .reg_rvalid              (reg_rvalid),
    .chip_addr_pin           (chip_addr_pin),
    .sample_strobe           (sample_strobe),
    .conv_data               (conv_data),
    .out_data                (out_data),
    .analog_tone_en          (analog_tone_en),
    .iq_swap                 (iq_swap),
    .preamp_offset_cancel_en (preamp_offset_cancel_en),
    .offset_cancel_gm        (offset_cancel_gm),
    .tone_force_lo           (tone_force_lo),
    .tone_force_dc           (tone_force_dc)
  );

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // The clock toggles every half period of 2.5 ns.
  always #2.5 clk = ~clk;

  // Prints the verdict and ends the run.
  task automatic finish_test;
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // Compares one value and reports a mismatch at once.
  task automatic check(input string nm, input logic [127:0] seen,
                       input logic [127:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Issues one write; called and returns on a falling edge. One idle
  // edge follows, so a next call never raises the strobe in the same
  // time step that lowered it.
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    @(negedge clk);
  endtask : wr

  // Issues one read and notes the data it must return.
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    rq.push_back(e);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    @(negedge clk);
  endtask : rd

  // Works out the channel words for one strobe and advances counters.
  function automatic logic [127:0] exp_data(input logic [127:0] cd);
    logic [127:0] r;
    logic [2:0]   nn;
    r = cd;
    for (int n = 0; n < 8; n++)
    begin
      nn = n[2:0];
      if (en[n] && sel == 3'h1)
        r[16*n +: 16] = sine[phase];
      else if (en[n] && sel == 3'h3)
        r[16*n +: 16] = {ramp, 1'b0, nn, chip_addr_pin};
    end
    phase = phase + 3'h1;
    if (sel == 3'h3)
      ramp = ramp + 7'h01;
    return r;
  endfunction : exp_data

  // ---------------------------------------------------------------
  // Result monitor
  // ---------------------------------------------------------------
  // Remembers that a strobe was taken, so its result is due next.
  always @(posedge clk)
    strb_seen <= sample_strobe & ~rst;

  // Takes the oldest note off a queue whenever a result appears.
  always @(negedge clk)
  begin
    if (!rst && reg_rvalid === 1'b1)
    begin
      if (rq.size() == 0)
        check("reg_rvalid", reg_rvalid, 1'b0);
      else
        check("reg_rdata", reg_rdata, rq.pop_front());
    end
    if (strb_seen && dq.size() > 0)
      check("out_data", out_data, dq.pop_front());
  end

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  // Bounds the whole run so a hang still reaches the verdict.
  initial
  begin
    #100000;
    failures++;
    finish_test();
  end

  // Main sequence: reset values, Doppler controls, test data path.
  initial
  begin
    seed = 7140;
    clk = 1'b0;
    rst = 1'b1;
    reg_addr = 13'h0_000;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    sample_strobe = 1'b0;
    conv_data = '0;
    failures = 0;
    checks = 0;
    chip_addr_pin = 5'($random(seed));
    sel = 3'h0;
    en = 8'h00;
    phase = 3'h0;
    ramp = 7'h00;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    check("preamp_cancel_en", preamp_offset_cancel_en, 1'b1);
    check("iq_swap", iq_swap, 1'b0);
    check("tone_force", {tone_force_lo, tone_force_dc}, 2'h0);
    check("analog_tone_en", analog_tone_en, 8'h00);
    rd(13'h0_11a, 8'h00);
    rd(13'h0_11b, 8'h00);
    for (int a = 28; a < 32; a++)
      rd(13'h0_100 | 13'(a), 8'h00);
    rd(13'h0_120, 8'h00);
    rd(13'h0_180, 8'h87);
    rd(13'h0_100, 8'h00);
    // Every override code, with random swap, cancel and gm bits.
    for (int i = 0; i < 8; i++)
    begin
      // Bits 7 and 2 are always written with their reset value of zero.
      v = (8'($random(seed)) & 8'h78) | 8'(i % 4);
      wr(13'h0_120, v);
      @(negedge clk);
      check("iq_swap", iq_swap, v[6]);
      check("preamp_cancel_en", preamp_offset_cancel_en, !v[5]);
      check("offset_cancel_gm", offset_cancel_gm, v[4:3]);
      check("tone_force_lo", tone_force_lo, v[1:0] == 2'h1);
      check("tone_force_dc", tone_force_dc, v[1]);
      rd(13'h0_120, v & 8'h7b);
    end
    // Every selection code, three back-to-back samples each.
    for (int c = 0; c < 8; c++)
    begin
      // Channels 0 and 1 always take part and channel 2 never does, so
      // the sine, identification and pass-through paths are all reached.
      en  = (8'($random(seed)) & 8'hfb) | 8'h03;
      sel = 3'(c);
      wr(13'h0_11a, en);
      wr(13'h0_11b, {5'h00, sel});
      @(negedge clk);
      check("tone_en", analog_tone_en, sel == 3'h4 ? en : 8'h00);
      rd(13'h0_11b, {5'h00, sel});
      sample_strobe = 1'b1;
      repeat (3)
      begin
        conv_data = {$random(seed), $random(seed), $random(seed),
                     $random(seed)};
        dq.push_back(exp_data(conv_data));
        @(negedge clk);
      end
      sample_strobe = 1'b0;
      @(negedge clk);
    end
    // A second reset in mid-run brings back the defaults.
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check("preamp_cancel_en", preamp_offset_cancel_en, 1'b1);
    check("analog_tone_en", analog_tone_en, 8'h00);
    rd(13'h0_11b, 8'h00);
    for (int k = 0; k < 20 && (rq.size() > 0 || dq.size() > 0); k++)
      @(negedge clk);
    if (rq.size() > 0 || dq.size() > 0)
      failures++;
    finish_test();
  end
endmodule : tb_tmcw_bank
